// ---- sensor_ctrl_pkg.sv ----
// Constants, types and helpers shared by the sensor command, reset and status controller.
// Assumes a 40 MHz system clock and a two-wire serial link sampled by that clock.
//
// Operation
// - Read header after fetch with no stored result is answered NACK, transfer ends.
// - Fetch command discards the stored result until a new measurement completes.
// - Break lets the running conversion finish, then single shot, within 15 ms.
// - Full system reset from soft reset command, reset pin low pulse, or power-up.
// - Commands arriving during a system reset are ignored.
// - Recovery sequence idles only the serial interface; status keeps its content.
// - Soft reset accepted when idle; resets controller and reloads calibration.
// - Calibration data is reloaded before every measurement.
// - General call address 0x00 then byte 0x06 resets like the reset pin.
// - General call reset is not device specific; every supporting device resets.
// - General call reset only acts while commands can be processed.
// - Reset pin is active low, must be held low at least 1 us.
// - Heater on and off commands act; heater state shows in the status word.
// - Heater starts disabled after any reset.
// - Status read returns heater, alert, command result and write checksum bits.
// - Clear status zeroes alert pending bit 15, tracking alert 10, reset detected 4.
// - Reset detected flag is set by every reset and held until clear status.
// - Command status bit set when last command was invalid, cleared otherwise.
// - Every 16-bit data word is followed by a CRC-8 over its two bytes.

package sensor_ctrl_pkg;

	// Timing.
	localparam int CLK_MHZ        = 40;
	localparam int PIN_LOW_NS     = 1000;
	localparam int PIN_LOW_CYC    = (PIN_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int BREAK_MS       = 15;
	localparam int BREAK_CYC      = BREAK_MS * CLK_MHZ * 1000;
	localparam int RST_BUSY_CYC   = 16;
	localparam int RECOVER_PULSES = 9;

	// Link addresses and fixed codes.
	localparam logic [6:0]  DEV_ADDR_DEF     = 7'h4a;
	localparam logic [6:0]  GC_ADDR          = 7'h00;
	localparam logic [7:0]  GC_RESET_BYTE    = 8'h06;
	localparam logic [15:0] CMD_CLEAR_STATUS = 16'h3041;
	localparam logic [15:0] CMD_PERIODIC_DEF = 16'h2130;
	localparam logic [15:0] CMD_FETCH_DEF    = 16'h1001;
	localparam logic [15:0] CMD_BREAK_DEF    = 16'h1002;
	localparam logic [15:0] CMD_SOFT_DEF     = 16'h1003;
	localparam logic [15:0] CMD_HEAT_ON_DEF  = 16'h1004;
	localparam logic [15:0] CMD_HEAT_OFF_DEF = 16'h1005;
	localparam logic [15:0] CMD_STATUS_DEF   = 16'h1006;

	// CRC-8 properties.
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;

	// APB map and fields.
	localparam logic [7:0] REG_EVENT       = 8'h00;
	localparam logic [7:0] REG_MEAS        = 8'h04;
	localparam logic [7:0] REG_STATUS      = 8'h08;
	localparam int         EV_CONV_BIT     = 0;
	localparam int         EV_ALERT_BIT    = 1;
	localparam int         EV_TRACK_BIT    = 2;
	localparam int         MEAS_VALID_BIT  = 16;
	localparam int         ST_PERIODIC_BIT = 16;
	localparam int         ST_CONV_BIT     = 17;
	localparam int         ST_BUSY_BIT     = 18;
	localparam int         ST_BREAK_BIT    = 19;

	// Status word as sent on the link.
	typedef struct packed {
		logic       alert;
		logic       rsv14;
		logic       heater;
		logic [1:0] rsv12;
		logic       track;
		logic [4:0] rsv9;
		logic       rst_seen;
		logic [1:0] rsv3;
		logic       cmd_err;
		logic       wr_crc_err;
	} status_t;

	// Link byte engine states.
	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_RECV = 3'b001,
		L_ACKW = 3'b010,
		L_ACK  = 3'b011,
		L_SEND = 3'b100,
		L_RACK = 3'b101,
		L_WAIT = 3'b110
	} link_state_t;

	// CRC-8 over two bytes, MSB first.
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
		begin
			c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8

endpackage : sensor_ctrl_pkg

// ---- sensor_cmd_reset_status_ctrl.sv ----
// Command interpreter, reset control and status word of a two-wire temperature sensor.
// Assumes SCL, SDA and the reset pin are asynchronous; the APB master runs on i_clock.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module sensor_cmd_reset_status_ctrl
	import sensor_ctrl_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR     = DEV_ADDR_DEF,
	parameter logic [15:0] CMD_FETCH    = CMD_FETCH_DEF,
	parameter logic [15:0] CMD_BREAK    = CMD_BREAK_DEF,
	parameter logic [15:0] CMD_SOFT     = CMD_SOFT_DEF,
	parameter logic [15:0] CMD_HEAT_ON  = CMD_HEAT_ON_DEF,
	parameter logic [15:0] CMD_HEAT_OFF = CMD_HEAT_OFF_DEF,
	parameter logic [15:0] CMD_STATUS   = CMD_STATUS_DEF,
	parameter logic [15:0] CMD_PERIODIC = CMD_PERIODIC_DEF,
	parameter int          BREAK_CYC_P  = BREAK_CYC
)
(
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Serial link pins.
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe_n,
	input  wire logic        i_reset_pin_active_low,
	// Sensor core.
	output logic             o_calib_reload,
	output logic             o_heater_on,
	output logic             o_periodic
);

	localparam int PW = $clog2(PIN_LOW_CYC + 1);
	localparam int BW = $clog2(BREAK_CYC_P + 1);
	localparam int RW = $clog2(RST_BUSY_CYC + 1);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic        scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, rpin_s1, rpin_s2;
	logic        scl_rise, scl_fall, bus_start, bus_stop;
	link_state_t state_r;
	logic [2:0]  cnt_r;
	logic [6:0]  shreg_r;
	logic [1:0]  idx_r;
	logic [7:0]  cmd_hi_r;
	logic [3:0]  rec_r;
	logic        first_r, gc_r, rw_r, ack_r, oe_n_r;
	logic [7:0]  byte_in, tx_byte;
	logic        byte_done, addr_hit, gc_hit, ack_nxt, cmd_go, gc_reset, soft_go, rd_hdr;
	logic [15:0] cmd_code;
	logic        known_cmd;
	logic [PW-1:0] pin_cnt_r;
	logic [RW-1:0] rst_cnt_r;
	logic        pin_trig, sys_trig, sys_busy;
	logic        heater_r, alert_r, track_r, rst_seen_r, cmd_err_r;
	status_t     status_w;
	logic [15:0] data_r;
	logic        valid_r, conv_r, periodic_r, brk_r, tx_avail_r, calib_r;
	logic [BW-1:0] brk_cnt_r;
	logic [23:0] tx_buf_r;
	logic [31:0] prdata_r;
	logic        apb_wr, ev_conv, ev_alert, ev_track, meas_wr, mapped;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage and later are looked at.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{rpin_s1, rpin_s2}       <= 2'h3;
		end
		else
		begin
			{scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
			{rpin_s1, rpin_s2}       <= {i_reset_pin_active_low, rpin_s1};
		end
	end

	// Bus events seen by the system clock.
	assign scl_rise  = scl_s2 & ~scl_s3;
	assign scl_fall  = ~scl_s2 & scl_s3;
	assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

	////////////////////////////////////////////////////////////////////////////
	// Byte decode and command classification.
	always_comb
	begin
		byte_in   = {shreg_r, sda_s2};
		byte_done = (state_r == L_RECV) && scl_rise && (cnt_r == 3'h7);
		addr_hit  = byte_in[7:1] == DEV_ADDR;
		gc_hit    = (byte_in[7:1] == GC_ADDR) && !byte_in[0];
		// A read is only acknowledged when something is queued for it.
		ack_nxt   = first_r ? (!sys_busy && ((addr_hit && (!byte_in[0] || tx_avail_r)) || gc_hit)) : 1'b1;
		cmd_code  = {cmd_hi_r, byte_in};
		cmd_go    = byte_done && !first_r && !gc_r && (idx_r == 2'h1);
		gc_reset  = byte_done && !first_r && gc_r && (idx_r == 2'h0) && (byte_in == GC_RESET_BYTE);
		soft_go   = cmd_go && (cmd_code == CMD_SOFT);
		rd_hdr    = byte_done && first_r && addr_hit && byte_in[0] && !sys_busy;
		known_cmd = (cmd_code == CMD_FETCH) || (cmd_code == CMD_BREAK) || (cmd_code == CMD_SOFT) ||
		            (cmd_code == CMD_HEAT_ON) || (cmd_code == CMD_HEAT_OFF) || (cmd_code == CMD_STATUS) ||
		            (cmd_code == CMD_CLEAR_STATUS) || (cmd_code == CMD_PERIODIC);
		unique case (idx_r)
			2'h0:    tx_byte = tx_buf_r[23:16];
			2'h1:    tx_byte = tx_buf_r[15:8];
			default: tx_byte = tx_buf_r[7:0];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Recovery counter: consecutive SCL rises with SDA high.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			rec_r <= 4'h0;
		else if (bus_start || (scl_rise && !sda_s2))
			rec_r <= 4'h0;
		else if (scl_rise && (rec_r != 4'(RECOVER_PULSES)))
			rec_r <= rec_r + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link byte engine. SDA is only ever pulled low; release lets the pull-up win.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_r  <= L_IDLE;
			cnt_r    <= 3'h0;
			shreg_r  <= 7'h00;
			idx_r    <= 2'h0;
			cmd_hi_r <= 8'h00;
			first_r  <= 1'b1;
			gc_r     <= 1'b0;
			rw_r     <= 1'b0;
			ack_r    <= 1'b0;
			oe_n_r   <= 1'b1;
		end
		else if (sys_trig)
		begin
			state_r <= L_WAIT;
			oe_n_r  <= 1'b1;
		end
		else if (bus_start)
		begin
			state_r <= L_RECV;
			cnt_r   <= 3'h0;
			first_r <= 1'b1;
			gc_r    <= 1'b0;
			idx_r   <= 2'h0;
			oe_n_r  <= 1'b1;
		end
		else if (bus_stop || (rec_r == 4'(RECOVER_PULSES)))
		begin
			// Only the interface returns to idle here; status bits are untouched.
			state_r <= L_IDLE;
			oe_n_r  <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				L_IDLE, L_WAIT: ;
				L_RECV:
					if (scl_rise)
					begin
						shreg_r <= byte_in[6:0];
						cnt_r   <= cnt_r + 3'h1;
						if (cnt_r == 3'h7)
						begin
							state_r <= L_ACKW;
							ack_r   <= ack_nxt;
							first_r <= 1'b0;
							if (first_r)
							begin
								rw_r  <= byte_in[0];
								gc_r  <= gc_hit;
								idx_r <= 2'h0;
							end
							else
							begin
								if (idx_r == 2'h0)
									cmd_hi_r <= byte_in;
								if (idx_r != 2'h2)
									idx_r <= idx_r + 2'h1;
							end
						end
					end
				L_ACKW:
					if (scl_fall)
					begin
						oe_n_r  <= ~ack_r;
						state_r <= ack_r ? L_ACK : L_WAIT;
					end
				L_ACK:
					if (scl_fall)
					begin
						oe_n_r  <= rw_r ? tx_byte[7] : 1'b1;
						cnt_r   <= rw_r ? 3'h1 : 3'h0;
						state_r <= rw_r ? L_SEND : L_RECV;
					end
				L_SEND:
					if (scl_fall)
					begin
						if (cnt_r != 3'h0)
						begin
							oe_n_r <= tx_byte[3'h7 - cnt_r];
							cnt_r  <= cnt_r + 3'h1;
						end
						else
						begin
							oe_n_r  <= 1'b1;
							state_r <= L_RACK;
							idx_r   <= idx_r + 2'h1;
						end
					end
				L_RACK:
					if (scl_rise)
						state_r <= (!sda_s2 && (idx_r != 2'h3)) ? L_ACK : L_WAIT;
				default: state_r <= L_WAIT;
			endcase
		end
	end

	assign o_sda      = 1'b0;
	assign o_sda_oe_n = oe_n_r;

	////////////////////////////////////////////////////////////////////////////
	// System reset: power-up, pin held low, soft command or general call.
	assign pin_trig = !rpin_s2 && (pin_cnt_r == PW'(PIN_LOW_CYC - 1));
	assign sys_trig = pin_trig || soft_go || gc_reset;
	assign sys_busy = rst_cnt_r != RW'(0);

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			pin_cnt_r <= PW'(0);
		else if (rpin_s2)
			pin_cnt_r <= PW'(0);
		else if (pin_cnt_r != PW'(PIN_LOW_CYC))
			pin_cnt_r <= pin_cnt_r + PW'(1);
	end

	// Power-up starts busy; a held pin keeps the device in reset.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			rst_cnt_r <= RW'(RST_BUSY_CYC);
		else if (sys_trig || (pin_cnt_r == PW'(PIN_LOW_CYC)))
			rst_cnt_r <= RW'(RST_BUSY_CYC);
		else if (sys_busy)
			rst_cnt_r <= rst_cnt_r - RW'(1);
	end

	////////////////////////////////////////////////////////////////////////////
	// Heater and status flags. Hardware sets win over a same-cycle clear.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			heater_r   <= 1'b0;
			alert_r    <= 1'b1;
			track_r    <= 1'b0;
			rst_seen_r <= 1'b1;
			cmd_err_r  <= 1'b0;
		end
		else if (sys_busy)
		begin
			heater_r   <= 1'b0;
			alert_r    <= 1'b1;
			track_r    <= 1'b0;
			rst_seen_r <= 1'b1;
			cmd_err_r  <= 1'b0;
		end
		else
		begin
			if (cmd_go)
			begin
				cmd_err_r <= !known_cmd;
				if (cmd_code == CMD_HEAT_ON)
					heater_r <= 1'b1;
				if (cmd_code == CMD_HEAT_OFF)
					heater_r <= 1'b0;
				if (cmd_code == CMD_CLEAR_STATUS)
				begin
					alert_r    <= 1'b0;
					track_r    <= 1'b0;
					rst_seen_r <= 1'b0;
				end
			end
			if (ev_alert)
				alert_r <= 1'b1;
			if (ev_track)
				track_r <= 1'b1;
		end
	end

	// Status word; no write data transfers exist, so its checksum flag stays clear.
	always_comb
	begin
		status_w            = '0;
		status_w.alert      = alert_r;
		status_w.heater     = heater_r;
		status_w.track      = track_r;
		status_w.rst_seen   = rst_seen_r;
		status_w.cmd_err    = cmd_err_r;
		status_w.wr_crc_err = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement store, acquisition mode and read queue.
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			data_r     <= 16'h0000;
			valid_r    <= 1'b0;
			conv_r     <= 1'b0;
			periodic_r <= 1'b0;
			brk_r      <= 1'b0;
			brk_cnt_r  <= BW'(0);
			tx_buf_r   <= 24'h000000;
			tx_avail_r <= 1'b0;
			calib_r    <= 1'b0;
		end
		else if (sys_busy)
		begin
			valid_r    <= 1'b0;
			conv_r     <= 1'b0;
			periodic_r <= 1'b0;
			brk_r      <= 1'b0;
			tx_avail_r <= 1'b0;
			// Calibration is reloaded as the controller leaves reset.
			calib_r    <= rst_cnt_r == RW'(1);
		end
		else
		begin
			calib_r <= ev_conv;
			if (ev_conv)
				conv_r <= 1'b1;
			if (cmd_go && (cmd_code == CMD_FETCH))
			begin
				tx_buf_r   <= {data_r, crc8(data_r)};
				tx_avail_r <= valid_r;
				valid_r    <= 1'b0;
			end
			else if (cmd_go && (cmd_code == CMD_STATUS))
			begin
				tx_buf_r   <= {status_w, crc8(status_w)};
				tx_avail_r <= 1'b1;
			end
			else if (cmd_go || rd_hdr)
				tx_avail_r <= 1'b0;
			// A finished conversion after the fetch refills the store.
			if (meas_wr)
			begin
				data_r  <= i_pwdata[15:0];
				valid_r <= 1'b1;
				conv_r  <= 1'b0;
			end
			if (cmd_go && (cmd_code == CMD_PERIODIC))
				periodic_r <= 1'b1;
			if (cmd_go && (cmd_code == CMD_BREAK) && periodic_r)
			begin
				brk_r     <= 1'b1;
				brk_cnt_r <= BW'(0);
			end
			else if (brk_r)
			begin
				// The bound guards against a conversion that never reports back.
				brk_cnt_r <= brk_cnt_r + BW'(1);
				if (!conv_r || (brk_cnt_r == BW'(BREAK_CYC_P - 1)))
				begin
					periodic_r <= 1'b0;
					brk_r      <= 1'b0;
				end
			end
		end
	end

	assign o_calib_reload = calib_r;
	assign o_heater_on    = heater_r;
	assign o_periodic     = periodic_r;

	////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states; read data is captured in the setup cycle.
	assign apb_wr   = i_psel && i_penable && i_pwrite;
	assign mapped   = (i_paddr == REG_EVENT) || (i_paddr == REG_MEAS) || (i_paddr == REG_STATUS);
	assign ev_conv  = apb_wr && (i_paddr == REG_EVENT) && i_pwdata[EV_CONV_BIT];
	assign ev_alert = apb_wr && (i_paddr == REG_EVENT) && i_pwdata[EV_ALERT_BIT];
	assign ev_track = apb_wr && (i_paddr == REG_EVENT) && i_pwdata[EV_TRACK_BIT];
	assign meas_wr  = apb_wr && (i_paddr == REG_MEAS);

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			prdata_r <= 32'h00000000;
		else if (i_psel && !i_penable)
		begin
			prdata_r <= 32'h00000000;
			if (i_paddr == REG_MEAS)
			begin
				prdata_r[15:0]           <= data_r;
				prdata_r[MEAS_VALID_BIT] <= valid_r;
			end
			if (i_paddr == REG_STATUS)
			begin
				prdata_r[15:0]            <= status_w;
				prdata_r[ST_PERIODIC_BIT] <= periodic_r;
				prdata_r[ST_CONV_BIT]     <= conv_r;
				prdata_r[ST_BUSY_BIT]     <= sys_busy;
				prdata_r[ST_BREAK_BIT]    <= brk_r;
			end
		end
	end

	assign o_prdata  = prdata_r;
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;

endmodule : sensor_cmd_reset_status_ctrl

`default_nettype wire

// ---- sensor_link_host.sv ----
// Bus master model for the two-wire link: it drives SCL and pulls SDA low when needed.
// Assumes the bench resolves SDA with a pull-up and feeds the line level back in.
`timescale 1ns/100ps
`default_nettype none

module sensor_link_host
(
	// Clock and line sense.
	input  wire logic i_clock,
	input  wire logic i_sda_line,
	// Line drive.
	output logic      o_scl,
	output logic      o_sda_low
);
	////////////////////////////////////////
	// The link idles with both lines released; SCL stands still between frames.
	initial
	begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	// One bit is eight system clocks, a 200 ns link period; SDA moves only while SCL is low.
	task automatic clk_bit(input logic b, output logic s);
		o_sda_low <= !b;
		repeat (4) @(posedge i_clock);
		o_scl <= 1'b1;
		repeat (3) @(posedge i_clock);
		s = i_sda_line;
		o_scl <= 1'b0;
		@(posedge i_clock);
	endtask : clk_bit

	// Start condition: SDA falls while SCL is high.
	task automatic start;
		o_sda_low <= 1'b0;
		o_scl     <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_sda_low <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_scl <= 1'b0;
		@(posedge i_clock);
	endtask : start

	// Stop condition: SDA rises while SCL is high.
	task automatic stop;
		o_sda_low <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_scl <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_sda_low <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask : stop

	// Eight bits MSB first, then the ninth clock samples the device's acknowledge.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask : wr_byte

	// Eight bits from the device, then our acknowledge; last leaves SDA high to end the read.
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(last, s);
	endtask : rd_byte

	// Nine clocks with SDA released; the caller must follow with a start.
	task automatic recover;
		logic s;
		repeat (9) clk_bit(1'b1, s);
	endtask : recover
endmodule : sensor_link_host
`default_nettype wire

// ---- sensor_ctrl_assertions.sv ----
// Port-level checks of the sensor command, reset and status controller.
// Assumes the zero-wait APB map of the package and a short busy period after every reset.
`timescale 1ns/100ps
`default_nettype none

module sensor_ctrl_assertions
	import sensor_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic        i_clock,
	input wire logic        i_rstn,
	// APB.
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// Pins and core.
	input wire logic        o_sda_oe_n,
	input wire logic        i_reset_pin_active_low,
	input wire logic        o_calib_reload,
	input wire logic        o_heater_on,
	input wire logic        o_periodic
);
	default clocking dc @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	////////////////////////////////////////
	// Saturating count of cycles the reset pin has been low; the design filters short pulses.
	logic [5:0] pin_low_r;
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			pin_low_r <= 6'h00;
		else if (i_reset_pin_active_low)
			pin_low_r <= 6'h00;
		else if (pin_low_r != 6'h3f)
			pin_low_r <= pin_low_r + 6'h01;
	end

	// Decode of the three mapped words.
	logic mapped;
	assign mapped = (i_paddr == REG_EVENT) || (i_paddr == REG_MEAS) || (i_paddr == REG_STATUS);

	////////////////////////////////////////
	sequence s_access;
		i_psel && i_penable;
	endsequence
	sequence s_boot;
		$rose(i_rstn);
	endsequence
	sequence s_quiet;
		o_sda_oe_n [*8];
	endsequence

	property p_unmapped;
		s_access ##0 !mapped |-> o_pslverr && (o_prdata == 32'h0);
	endproperty
	property p_mapped;
		s_access ##0 mapped |-> !o_pslverr && o_pready;
	endproperty
	property p_err_idle;
		!i_penable |-> !o_pslverr;
	endproperty
	property p_boot_clear;
		s_boot |-> !o_heater_on && !o_periodic;
	endproperty
	property p_boot_quiet;
		s_boot |-> s_quiet;
	endproperty
	property p_boot_reload;
		s_boot |-> ##[1:20] o_calib_reload;
	endproperty
	property p_pulse;
		o_calib_reload |=> !o_calib_reload;
	endproperty
	property p_conv_reload;
		s_access ##0 (i_pwrite && i_paddr == REG_EVENT && i_pwdata[EV_CONV_BIT]) |-> ##[1:3] o_calib_reload;
	endproperty
	property p_pin_reset;
		pin_low_r >= 6'h30 |-> !o_heater_on && !o_periodic && o_sda_oe_n;
	endproperty

	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	a_err_idle: assert property (p_err_idle) else $error("error outside access");
	a_boot_clear: assert property (p_boot_clear) else $error("heater or periodic after reset");
	a_boot_quiet: assert property (p_boot_quiet) else $error("link driven during reset");
	a_boot_reload: assert property (p_boot_reload) else $error("no reload after reset");
	a_pulse: assert property (p_pulse) else $error("reload longer than a cycle");
	a_conv_reload: assert property (p_conv_reload) else $error("no reload at conversion");
	a_pin_reset: assert property (p_pin_reset) else $error("pin held low without reset");
endmodule : sensor_ctrl_assertions

bind sensor_cmd_reset_status_ctrl sensor_ctrl_assertions i_chk
(
	.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_sda_oe_n(o_sda_oe_n),
	.i_reset_pin_active_low(i_reset_pin_active_low), .o_calib_reload(o_calib_reload),
	.o_heater_on(o_heater_on), .o_periodic(o_periodic)
);
`default_nettype wire

// ---- sensor_cmd_reset_status_ctrl_bench.sv ----
// Self-checking bench of the sensor command, reset and status controller.
// Assumes the link master model and the assertion checker are compiled beside it.
`timescale 1ns/100ps
`default_nettype none

module sensor_cmd_reset_status_ctrl_bench
	import sensor_ctrl_pkg::*;
;
	localparam int BRK = 50;
	typedef struct packed {logic [15:0] code; logic [15:0] st; logic per;} row_t;
	logic        clock, rstn, psel, penable, pwrite, reset_pin_active_low, scl, host_low, a, e;
	logic        sda_out, sda_oe_n, pready, pslverr, calib, heater, periodic;
	logic [7:0]  paddr, c;
	logic [15:0] w;
	logic [31:0] pwdata, prdata, q;
	wire logic   sda_line;
	int          fail_count = 0, samples_checked = 0, cycles = 0, n;
	row_t        rows [6] = '{'{CMD_HEAT_ON_DEF, 16'ha010, 1'b0}, '{16'habcd, 16'ha012, 1'b0},
		'{CMD_HEAT_OFF_DEF, 16'h8010, 1'b0}, '{CMD_BREAK_DEF, 16'h8010, 1'b0},
		'{CMD_PERIODIC_DEF, 16'h8010, 1'b1}, '{CMD_FETCH_DEF, 16'h8010, 1'b1}};

	////////////////////////////////////////
	// SDA has a pull-up, so it is low only while someone pulls it.
	assign sda_line = !(host_low || (!sda_oe_n && !sda_out));

	sensor_cmd_reset_status_ctrl #(.BREAK_CYC_P(BRK)) i_dut
	(
		.i_clock(clock), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_scl(scl), .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_reset_pin_active_low(reset_pin_active_low), .o_calib_reload(calib),
		.o_heater_on(heater), .o_periodic(periodic)
	);
	sensor_link_host i_host (.i_clock(clock), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(host_low));

	// 40 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = !clock;
	end

	// A hang is cut short well beyond the few thousand cycles the run needs.
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			close_out();
		end
	end

	////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Status flags through APB, reserved bits masked off.
	task automatic st(input logic [15:0] exp);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", {16'h0, exp}, q & 32'h0000a413);
	endtask : st

	task automatic cmd(input logic [15:0] code);
		logic a0, a1, a2;
		i_host.start();
		i_host.wr_byte({DEV_ADDR_DEF, 1'b0}, a0);
		i_host.wr_byte(code[15:8], a1);
		i_host.wr_byte(code[7:0], a2);
		i_host.stop();
		chk("cmd ack", 32'h3, {30'h0, a0, a1});
	endtask : cmd

	// Read header; on acknowledge, word and checksum follow.
	task automatic rd(input logic ok);
		i_host.start();
		i_host.wr_byte({DEV_ADDR_DEF, 1'b1}, a);
		chk("read ack", {31'h0, ok}, {31'h0, a});
		if (a)
		begin
			i_host.rd_byte(1'b0, w[15:8]);
			i_host.rd_byte(1'b0, w[7:0]);
			i_host.rd_byte(1'b1, c);
		end
		i_host.stop();
	endtask : rd

	function automatic logic [7:0] crc_of(input logic [15:0] d);
		logic [7:0] r;
		r = 8'hff;
		for (int i = 15; i >= 0; i--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h31 : 8'h00);
		return r;
	endfunction : crc_of

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	////////////////////////////////////////
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		reset_pin_active_low = 1'b1;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		repeat (20) @(posedge clock);
		st(16'h8010);
		foreach (rows[i])
		begin
			cmd(rows[i].code);
			st(rows[i].st);
			chk("periodic", {31'h0, rows[i].per}, {31'h0, periodic});
			chk("heater", {31'h0, rows[i].st[13]}, {31'h0, heater});
		end
		apb(1'b1, REG_MEAS, 32'h0000beef);
		cmd(CMD_FETCH_DEF);
		rd(1'b1);
		chk("fetch", 32'h0000be92, {16'h0, w[15:8], c});
		chk("fetch lsb", 32'hef, {24'h0, w[7:0]});
		apb(1'b0, REG_MEAS, 32'h0);
		chk("valid", 32'h0, {31'h0, q[MEAS_VALID_BIT]});
		cmd(CMD_FETCH_DEF);
		rd(1'b0);
		apb(1'b1, REG_EVENT, 32'h1);
		cmd(CMD_BREAK_DEF);
		chk("periodic", 32'h1, {31'h0, periodic});
		apb(1'b1, REG_MEAS, 32'h1234);
		for (n = 0; n < BRK && periodic !== 1'b0; n++)
			@(posedge clock);
		chk("periodic", 32'h0, {31'h0, periodic});
		apb(1'b1, REG_EVENT, 32'h6);
		st(16'h8410);
		cmd(CMD_STATUS_DEF);
		rd(1'b1);
		chk("link status", 32'h8410, {16'h0, w & 16'ha413});
		chk("crc", {24'h0, crc_of(w)}, {24'h0, c});
		cmd(CMD_CLEAR_STATUS);
		st(16'h0000);
		i_host.start();
		i_host.recover();
		cmd(CMD_HEAT_ON_DEF);
		st(16'h2000);
		cmd(CMD_SOFT_DEF);
		repeat (20) @(posedge clock);
		st(16'h8010);
		cmd(CMD_HEAT_ON_DEF);
		cmd(CMD_CLEAR_STATUS);
		i_host.start();
		i_host.wr_byte(8'h00, a);
		chk("gc ack", 32'h1, {31'h0, a});
		i_host.wr_byte(GC_RESET_BYTE, a);
		i_host.stop();
		repeat (20) @(posedge clock);
		st(16'h8010);
		cmd(CMD_HEAT_ON_DEF);
		cmd(CMD_CLEAR_STATUS);
		reset_pin_active_low <= 1'b0;
		repeat (48) @(posedge clock);
		i_host.start();
		i_host.wr_byte({DEV_ADDR_DEF, 1'b0}, a);
		i_host.stop();
		chk("busy ack", 32'h0, {31'h0, a});
		reset_pin_active_low <= 1'b1;
		repeat (20) @(posedge clock);
		st(16'h8010);
		apb(1'b1, 8'h0c, 32'hffffffff);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		cmd(CMD_HEAT_ON_DEF);
		cmd(CMD_CLEAR_STATUS);
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (20) @(posedge clock);
		st(16'h8010);
		close_out();
	end
endmodule : sensor_cmd_reset_status_ctrl_bench
`default_nettype wire
